// *** pkg/frr_pkg.sv ***
`default_nettype none
package frr_pkg;
  typedef enum logic [2:0] {
    FRR_RUN,
    FRR_WAIT,
    FRR_TRY,
    FRR_LATCHED
  } frr_state_t;
endpackage
`default_nettype wire

// *** pkg/frr_regs.svh ***
`ifndef FRR_REGS_SVH
`define FRR_REGS_SVH
`define FRR_RETRY_W 3
`define FRR_DELAY_W 3
`define FRR_RETRY_NONE 3'h0
`define FRR_RETRY_ONCE 3'h1
`define FRR_RETRY_TWICE 3'h2
`define FRR_RETRY_THRICE 3'h3
`define FRR_UNIT_W 16
`endif

// *** testbench/fault_restart_retry_control_tb.sv ***
`default_nettype none
module fault_restart_retry_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 0, nrst_i = 0, trip = 0, clr = 0, ld = 0, prev_en = 1;
  logic fault, en, lat, att;
  logic [1:0] fl = 0;
  logic [2:0] rt = 0, dl = 0;
  logic [15:0] un = 16'h1;
  int err_total = 0, tests_run = 0, gap = 0, na = 0, xg = 1;
  always #5 mclk_i = ~mclk_i;
  frr_retry_ctrl i_frr_retry_ctrl (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .fault_i(fault), .fault_clear_i(clr), .retry_i(rt), .delay_i(dl),
    .unit_i(un), .out_en_o(en), .latched_off_o(lat), .attempt_o(att));
  frr_fault_src i_frr_fault_src (.mclk_i(mclk_i), .load_i(ld),
    .fails_i(fl), .trip_i(trip), .attempt_i(att), .fault_o(fault));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Codes above three behave as three.
  function automatic int exp_tries(input logic [2:0] c);
    exp_tries = (c > 3'h3) ? 3 : int'(c);
  endfunction
  // A unit of zero counts as one cycle; one more cycle reaches the pulse.
  function automatic int exp_gap(input logic [2:0] d,
                                 input logic [15:0] u);
    exp_gap = int'(d) * ((u == 16'h0) ? 1 : int'(u)) + 1;
  endfunction
  // Gap counts low cycles from shutdown to the restart pulse.
  always @(negedge mclk_i)
  begin
    gap = (prev_en && !en) ? 0 : gap + 1;
    prev_en = en;
    if (att === 1'b1)
    begin
      na++;
      chk(gap, xg);
      chk(en, 1'b1);
    end
  end
  task automatic run(input logic [2:0] c, input logic [2:0] d,
                     input logic [15:0] u, input logic [1:0] f);
    int n;
    n = exp_tries(c);
    xg = exp_gap(d, u);
    na = 0;
    @(posedge mclk_i);
    rt <= c;
    dl <= d;
    un <= u;
    fl <= f;
    ld <= 1;
    trip <= 1;
    @(posedge mclk_i);
    ld <= 0;
    trip <= 0;
    repeat (4 * xg + 12) @(posedge mclk_i);
    @(negedge mclk_i);
    if (f < n)
    begin
      chk(na, f + 1);
      chk({lat, en}, 2'b01);
    end
    else
    begin
      chk(na, n);
      chk({lat, en}, 2'b10);
    end
    @(posedge mclk_i);
    clr <= 1;
    @(posedge mclk_i);
    clr <= 0;
    @(negedge mclk_i);
    chk({lat, en}, 2'b01);
  endtask
  initial
  begin
    void'($urandom(12482));
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1;
    @(negedge mclk_i);
    chk({lat, en}, 2'b01);
    for (int c = 0; c < 8; c++)
      run(3'(c), 3'($urandom), 16'($urandom % 4 + 1), 2'h3);
    run(3'h3, 3'h7, 16'h4, 2'h2);
    run(3'h2, 3'h0, 16'h1, 2'h1);
    run(3'h1, 3'h0, 16'h3, 2'h0);
    run(3'h1, 3'h2, 16'h0, 2'h1);
    repeat (12)
      run(3'($urandom), 3'($urandom), 16'($urandom % 4 + 1),
          2'($urandom));
    conclude;
  end
endmodule
`default_nettype wire

// *** testbench/frr_fault_src.sv ***
`default_nettype none
module frr_fault_src (
  input wire logic mclk_i,        // Clock
  input wire logic load_i,        // Load the fail count
  input wire logic [1:0] fails_i, // Attempts to make fail
  input wire logic trip_i,        // Fault request from bench
  input wire logic attempt_i,     // Restart pulse from block
  output logic fault_o            // Fault seen by block
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] left_ff = 2'h0;
  // fault returns
  // The fault reappears while the output is back on, as a real one would.
  assign fault_o = trip_i | (attempt_i & (left_ff != 2'h0));
  always_ff @(posedge mclk_i)
  begin
    if (load_i)
      left_ff <= fails_i;
    else if (attempt_i && left_ff != 2'h0)
      left_ff <= left_ff - 2'h1;
  end
endmodule
`default_nettype wire

// *** verilog/frr_retry_ctrl.sv ***
`include "frr_regs.svh"
`default_nettype none
module frr_retry_ctrl
  import frr_pkg::*;
#(
  parameter int RETRY_W = `FRR_RETRY_W,
  parameter int DELAY_W = `FRR_DELAY_W,
  parameter int UNIT_W = `FRR_UNIT_W
)(
  input wire logic mclk_i,                  // Clock, 100 MHz
  input wire logic nrst_i,                  // Sync reset, active low
  input wire logic fault_i,                 // Fault detected pulse/level
  input wire logic fault_clear_i,           // Fault cleared pulse
  input wire logic [RETRY_W-1:0] retry_i,   // Retry-count setting
  input wire logic [DELAY_W-1:0] delay_i,   // Delay multiplier field
  input wire logic [UNIT_W-1:0] unit_i,     // Delay unit in clock cycles
  output logic out_en_o,                    // Output enable
  output logic latched_off_o,               // Held off until clear
  output logic attempt_o                    // One-cycle restart pulse
);
  import frr_pkg::*;

  frr_state_t state_ff, nxt_state;
  logic [1:0] left_ff, nxt_left;
  logic [DELAY_W-1:0] mult_ff, nxt_mult;
  logic [UNIT_W-1:0] unit_ff, nxt_unit;
  logic [UNIT_W-1:0] tick_ff, nxt_tick;
  logic out_en_ff, nxt_out_en;
  logic attempt_ff, nxt_attempt;

  // Settings above three are treated as three; only codes zero to three have their own names.
  function automatic logic [1:0] tries(input logic [RETRY_W-1:0] r);
    if (r == `FRR_RETRY_NONE) tries = 2'h0;
    else if (r == `FRR_RETRY_ONCE) tries = 2'h1;
    else if (r == `FRR_RETRY_TWICE) tries = 2'h2;
    else tries = 2'h3;
  endfunction

  always_comb
  begin
    nxt_state = state_ff;
    nxt_left = left_ff;
    nxt_mult = mult_ff;
    nxt_unit = unit_ff;
    nxt_tick = tick_ff;
    nxt_out_en = out_en_ff;
    nxt_attempt = 1'b0;
    case (state_ff)
      FRR_RUN:
      begin
        if (fault_i)
        begin
          nxt_out_en = 1'b0;
          nxt_mult = delay_i;
          nxt_unit = (unit_i == '0) ? {{(UNIT_W-1){1'b0}}, 1'b1} : unit_i;
          nxt_tick = '0;
          nxt_left = tries(retry_i);
          if (tries(retry_i) == 2'h0)
            nxt_state = FRR_LATCHED;
          else
            nxt_state = FRR_WAIT;
        end
      end
      FRR_WAIT:
      begin
        if (mult_ff == '0)
        begin
          nxt_state = FRR_TRY;
          nxt_out_en = 1'b1;
          nxt_attempt = 1'b1;
          nxt_left = left_ff - 2'h1;
        end
        else if (tick_ff == unit_ff - {{(UNIT_W-1){1'b0}}, 1'b1})
        begin
          nxt_tick = '0;
          nxt_mult = mult_ff - {{(DELAY_W-1){1'b0}}, 1'b1};
        end
        else
          nxt_tick = tick_ff + {{(UNIT_W-1){1'b0}}, 1'b1};
      end
      FRR_TRY:
      begin
        if (fault_i)
        begin
          nxt_out_en = 1'b0;
          nxt_mult = delay_i;
          nxt_tick = '0;
          if (left_ff == 2'h0)
            nxt_state = FRR_LATCHED;
          else
            nxt_state = FRR_WAIT;
        end
        else
          nxt_state = FRR_RUN;
      end
      FRR_LATCHED:
      begin
        nxt_out_en = 1'b0;
        if (fault_clear_i)
        begin
          nxt_state = FRR_RUN;
          nxt_out_en = 1'b1;
        end
      end
      default: nxt_state = FRR_LATCHED;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      state_ff <= FRR_RUN;
      left_ff <= 2'h0;
      mult_ff <= '0;
      unit_ff <= '0;
      tick_ff <= '0;
      out_en_ff <= 1'b1;
      attempt_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      left_ff <= nxt_left;
      mult_ff <= nxt_mult;
      unit_ff <= nxt_unit;
      tick_ff <= nxt_tick;
      out_en_ff <= nxt_out_en;
      attempt_ff <= nxt_attempt;
    end
  end

  assign out_en_o = out_en_ff;
  assign attempt_o = attempt_ff;
  assign latched_off_o = (state_ff == FRR_LATCHED);

  property p_zero_latch;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state_ff == FRR_RUN && fault_i && retry_i == `FRR_RETRY_NONE)
      |=> latched_off_o && !out_en_o;
  endproperty
  a_zero_latch: assert property (p_zero_latch)
    else $error("zero retry did not latch off");

  property p_latched_off;
    @(posedge mclk_i) disable iff (!nrst_i)
      latched_off_o && !fault_clear_i |=> !out_en_o && latched_off_o;
  endproperty
  a_latched_off: assert property (p_latched_off)
    else $error("output came back without clear");

  property p_once;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state_ff == FRR_RUN && fault_i && retry_i == `FRR_RETRY_ONCE)
      |=> left_ff == 2'h1;
  endproperty
  a_once: assert property (p_once)
    else $error("retry once loaded wrong count");

  property p_twice;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state_ff == FRR_RUN && fault_i && retry_i == `FRR_RETRY_TWICE)
      |=> left_ff == 2'h2;
  endproperty
  a_twice: assert property (p_twice)
    else $error("retry twice loaded wrong count");

  property p_thrice;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state_ff == FRR_RUN && fault_i && retry_i == `FRR_RETRY_THRICE)
      |=> left_ff == 2'h3;
  endproperty
  a_thrice: assert property (p_thrice)
    else $error("retry three loaded wrong count");

  property p_exhaust;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state_ff == FRR_TRY && fault_i && left_ff == 2'h0)
      |=> latched_off_o;
  endproperty
  a_exhaust: assert property (p_exhaust)
    else $error("exhausted retries did not latch");

  property p_no_early;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state_ff == FRR_WAIT && mult_ff != '0) |=> !attempt_o;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("attempt before delay ran out");

  property p_fail;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state_ff == FRR_TRY && fault_i) |=> !out_en_o;
  endproperty
  a_fail: assert property (p_fail)
    else $error("failed attempt left output on");

  // attempt tally
  // Check-only tally of restarts since the fault that left normal run. It
  // works the allowed count out from the setting, not from left_ff, so a
  // broken countdown cannot hide behind its own state.
  logic [2:0] seen_ff, nxt_seen;
  logic [1:0] cap_ff, nxt_cap;

  always_comb
  begin
    nxt_seen = seen_ff;
    nxt_cap = cap_ff;
    if (state_ff == FRR_RUN && fault_i)
    begin
      nxt_seen = 3'h0;
      if (retry_i > `FRR_RETRY_THRICE)
        nxt_cap = 2'h3;
      else
        nxt_cap = retry_i[1:0];
    end
    else if (attempt_o)
      nxt_seen = seen_ff + 3'h1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      seen_ff <= 3'h0;
      cap_ff <= 2'h0;
    end
    else
    begin
      seen_ff <= nxt_seen;
      cap_ff <= nxt_cap;
    end
  end

  property p_attempt_cap;
    @(posedge mclk_i) disable iff (!nrst_i)
      attempt_o |-> seen_ff < {1'b0, cap_ff};
  endproperty
  a_attempt_cap: assert property (p_attempt_cap)
    else $error("more restarts than the setting allows");

  property p_give_up_count;
    @(posedge mclk_i) disable iff (!nrst_i)
      $rose(latched_off_o) |-> seen_ff == {1'b0, cap_ff};
  endproperty
  a_give_up_count: assert property (p_give_up_count)
    else $error("latched off after the wrong number of restarts");

  c_attempt: cover property (@(posedge mclk_i) attempt_o);
  c_latch: cover property (@(posedge mclk_i)
    state_ff == FRR_TRY ##1 latched_off_o);
  c_recover: cover property (@(posedge mclk_i)
    state_ff == FRR_TRY && !fault_i);
endmodule
`default_nettype wire
